// file: design/ces_pkg.sv
// Constants and types for the carrier edge shaping block.
// Assumes a single clock domain and a carrier tick supplied by the RF core.
package ces_pkg;

	// Register indices; byte address is four times the index
	localparam int unsigned REG_IDX_TYPE     = 'h3d;
	localparam int unsigned REG_IDX_TIMING   = 'h3e;
	localparam int unsigned REG_IDX_LENGTH   = 'h3f;
	localparam int unsigned REG_IDX_RESIDUAL = 'h40;
	localparam int unsigned REG_IDX_STATUS   = 'h41;
	localparam int unsigned ADDR_W           = 12;
	localparam int unsigned BYTE_SHIFT       = 2;

	// Reset values of the configuration registers
	localparam logic [7:0] RST_TYPE     = 8'h00;
	localparam logic [7:0] RST_TIMING   = 8'h00;
	localparam logic [7:0] RST_LENGTH   = 8'h00;
	localparam logic [7:0] RST_RESIDUAL = 8'h00;

	// Writable bit masks; reserved bits store and read as zero
	localparam logic [7:0] MASK_TYPE     = 8'hff;
	localparam logic [7:0] MASK_TIMING   = 8'h77;
	localparam logic [7:0] MASK_LENGTH   = 8'h9f;
	localparam logic [7:0] MASK_RESIDUAL = 8'hff;

	// Field positions
	localparam int unsigned FALL_CODE_LSB = 4;
	localparam int unsigned RISE_CODE_LSB = 0;
	localparam int unsigned FALL_SEL_LSB  = 4;
	localparam int unsigned RISE_SEL_LSB  = 0;
	localparam int unsigned STRETCH_BIT   = 7;
	localparam int unsigned COUNT_LSB     = 0;
	localparam int unsigned COUNT_W       = 5;

	// Edge style codes
	localparam logic [3:0] CODE_LIN1     = 4'h1;
	localparam logic [3:0] CODE_LIN2     = 4'h2;
	localparam logic [3:0] CODE_LIN3     = 4'h3;
	localparam logic [3:0] CODE_LUT      = 4'h4;
	localparam logic [3:0] CODE_LUT_CORR = 4'h5;
	localparam logic [3:0] CODE_LUT_ADPT = 4'h6;
	localparam logic [2:0] LUT_SEL_MAX   = 3'h3;

	// Amplitude levels
	localparam logic [7:0] LEVEL_FULL = 8'hff;

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Decoded description of one edge
	typedef struct packed {
		logic       fwShaping;
		logic       lutShaping;
		logic [1:0] segments;
		logic [2:0] timeConst;
		logic [1:0] lutIndex;
		logic       supplyAdapt;
		logic       supplyCorrect;
		logic       reservedCode;
	} ces_shape_t;

	typedef enum {
		CES_FULL,
		CES_FALL,
		CES_LOW,
		CES_RISE
	} ces_state_t;

endpackage : ces_pkg

// file: design/ces_edge_if.sv
// Carries one edge's raw setting fields to the decoder and its result back.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface ces_edge_if;
	logic [3:0]          typeCode;
	logic [2:0]          styleSel;
	ces_pkg::ces_shape_t shape;

	modport dec (input typeCode, input styleSel, output shape);
	modport user (output typeCode, output styleSel, input shape);
endinterface : ces_edge_if
`default_nettype wire

// file: design/ces_edge_decode.sv
// Decodes one edge's style code and style selection into a shape description.
// Assumes fields come straight from the configuration registers.
`timescale 1ns/1ps
`default_nettype none
module ces_edge_decode (
	// Edge fields in, shape out
	ces_edge_if.dec edge_io
);
	// Code meanings are identical for both edges
	always_comb begin
		edge_io.shape = '0;
		case (edge_io.typeCode)
			ces_pkg::CODE_LIN1, ces_pkg::CODE_LIN2,
			ces_pkg::CODE_LIN3: begin
				edge_io.shape.fwShaping = 1'b1;
				edge_io.shape.segments  = edge_io.typeCode[1:0];
				edge_io.shape.timeConst = edge_io.styleSel;
			end
			ces_pkg::CODE_LUT: begin
				edge_io.shape.lutShaping = 1'b1;
			end
			ces_pkg::CODE_LUT_CORR: begin
				edge_io.shape.lutShaping    = 1'b1;
				edge_io.shape.supplyAdapt   = 1'b1;
				edge_io.shape.supplyCorrect = 1'b1;
			end
			ces_pkg::CODE_LUT_ADPT: begin
				edge_io.shape.lutShaping  = 1'b1;
				edge_io.shape.supplyAdapt = 1'b1;
			end
			default: begin
				edge_io.shape.reservedCode = 1'b1;
			end
		endcase
		if (edge_io.shape.lutShaping) begin
			edge_io.shape.lutIndex = edge_io.styleSel[1:0];
			if (edge_io.styleSel > ces_pkg::LUT_SEL_MAX) begin
				edge_io.shape.reservedCode = 1'b1;
			end
		end
	end
endmodule : ces_edge_decode
`default_nettype wire

// file: design/ces_shaper.sv
// Carrier edge shaper: AXI4-Lite configuration and an edge sequencer that
// ramps the carrier amplitude between full and residual level.
// Assumes carrierTick pulses once per carrier cycle, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ces_shaper (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write channels
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Carrier timing and modulation request
	input  wire logic        carrierTick,
	input  wire logic        modActive,
	// Shaped amplitude and active edge description
	output logic [7:0]       amplitude,
	output logic [4:0]       edgeStep,
	output logic             edgeBusy,
	output logic             edgeFalling,
	output ces_pkg::ces_shape_t activeShape
);
	localparam int unsigned AW = ces_pkg::ADDR_W;
	localparam int unsigned CW = ces_pkg::COUNT_W;

	// Byte addresses of the registers
	localparam logic [AW-1:0] ADDR_TYPE =
		AW'(ces_pkg::REG_IDX_TYPE << ces_pkg::BYTE_SHIFT);
	localparam logic [AW-1:0] ADDR_TIMING =
		AW'(ces_pkg::REG_IDX_TIMING << ces_pkg::BYTE_SHIFT);
	localparam logic [AW-1:0] ADDR_LENGTH =
		AW'(ces_pkg::REG_IDX_LENGTH << ces_pkg::BYTE_SHIFT);
	localparam logic [AW-1:0] ADDR_RESIDUAL =
		AW'(ces_pkg::REG_IDX_RESIDUAL << ces_pkg::BYTE_SHIFT);
	localparam logic [AW-1:0] ADDR_STATUS =
		AW'(ces_pkg::REG_IDX_STATUS << ces_pkg::BYTE_SHIFT);

	// Configuration registers
	logic [7:0]    edgeShapeTypeA,      next_edgeShapeTypeA;
	logic [7:0]    edgeShapeTimingA,    next_edgeShapeTimingA;
	logic [7:0]    edgeShapeLengthA,    next_edgeShapeLengthA;
	logic [7:0]    residualCarrierLevelB, next_residualCarrierLevelB;
	// Write and read channel state
	logic          awHeld,   next_awHeld;
	logic [AW-1:0] awAddrQ,  next_awAddrQ;
	logic          wHeld,    next_wHeld;
	logic [7:0]    wByteQ,   next_wByteQ;
	logic          wLaneQ,   next_wLaneQ;
	logic          next_bvalid;
	logic [1:0]    next_bresp;
	logic          next_rvalid;
	logic [31:0]   next_rdata;
	logic [1:0]    next_rresp;
	// Sequencer state
	ces_pkg::ces_state_t state, next_state;
	logic [7:0]    next_amplitude;
	logic [CW-1:0] next_edgeStep;
	logic [CW-1:0] edgeLen,   next_edgeLen;
	logic          edgeStretch, next_edgeStretch;
	logic          holdCnt,   next_holdCnt;
	logic [7:0]    edgeDelta, next_edgeDelta;
	logic [7:0]    edgeTarget, next_edgeTarget;
	logic [CW-1:0] errAcc,    next_errAcc;
	logic          next_edgeFalling;
	ces_pkg::ces_shape_t next_activeShape;
	ces_pkg::ces_shape_t edgeShape [2];

	// One decoder per edge: index 0 falling, index 1 rising
	for (genvar e = 0; e < 2; e++) begin : g_edge
		ces_edge_if edgeBus ();
		ces_edge_decode u_dec (
			.edge_io (edgeBus.dec)
		);
		if (e == 0) begin : g_fall
			assign edgeBus.typeCode = edgeShapeTypeA[
				ces_pkg::FALL_CODE_LSB +: 4];
			assign edgeBus.styleSel = edgeShapeTimingA[
				ces_pkg::FALL_SEL_LSB +: 3];
		end else begin : g_rise
			assign edgeBus.typeCode = edgeShapeTypeA[
				ces_pkg::RISE_CODE_LSB +: 4];
			assign edgeBus.styleSel = edgeShapeTimingA[
				ces_pkg::RISE_SEL_LSB +: 3];
		end
		assign edgeShape[e] = edgeBus.shape;
	end

	// Handshake readies
	assign awready = !awHeld && !bvalid;
	assign wready  = !wHeld && !bvalid;
	assign arready = !rvalid;

	// Write path: address and data taken in either order, then one response
	always_comb begin
		next_awHeld   = awHeld;
		next_awAddrQ  = awAddrQ;
		next_wHeld    = wHeld;
		next_wByteQ   = wByteQ;
		next_wLaneQ   = wLaneQ;
		next_bvalid   = bvalid;
		next_bresp    = bresp;
		next_edgeShapeTypeA        = edgeShapeTypeA;
		next_edgeShapeTimingA      = edgeShapeTimingA;
		next_edgeShapeLengthA      = edgeShapeLengthA;
		next_residualCarrierLevelB = residualCarrierLevelB;
		if (awvalid && awready) begin
			next_awHeld  = 1'b1;
			next_awAddrQ = awaddr;
		end
		if (wvalid && wready) begin
			next_wHeld  = 1'b1;
			next_wByteQ = wdata[7:0];
			next_wLaneQ = wstrb[0];
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (awHeld && wHeld && !bvalid) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = ces_pkg::RESP_OKAY;
			case (awAddrQ)
				ADDR_TYPE: if (wLaneQ) begin
					next_edgeShapeTypeA = wByteQ & ces_pkg::MASK_TYPE;
				end
				ADDR_TIMING: if (wLaneQ) begin
					next_edgeShapeTimingA = wByteQ & ces_pkg::MASK_TIMING;
				end
				ADDR_LENGTH: if (wLaneQ) begin
					next_edgeShapeLengthA = wByteQ & ces_pkg::MASK_LENGTH;
				end
				ADDR_RESIDUAL: if (wLaneQ) begin
					next_residualCarrierLevelB =
						wByteQ & ces_pkg::MASK_RESIDUAL;
				end
				ADDR_STATUS: ;                         // Read only, ignored
				default: next_bresp = ces_pkg::RESP_DECERR;
			endcase
		end
	end

	// Read path: answer one cycle after the address is taken
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = ces_pkg::RESP_OKAY;
			next_rdata  = '0;
			case (araddr)
				ADDR_TYPE:     next_rdata[7:0] = edgeShapeTypeA;
				ADDR_TIMING:   next_rdata[7:0] = edgeShapeTimingA;
				ADDR_LENGTH:   next_rdata[7:0] = edgeShapeLengthA;
				ADDR_RESIDUAL: next_rdata[7:0] = residualCarrierLevelB;
				ADDR_STATUS: begin
					next_rdata[7:0]   = amplitude;
					next_rdata[12:8]  = edgeStep;
					next_rdata[16]    = edgeBusy;
					next_rdata[17]    = edgeFalling;
					next_rdata[18]    = edgeShape[0].reservedCode;
					next_rdata[19]    = edgeShape[1].reservedCode;
				end
				default: next_rresp = ces_pkg::RESP_DECERR;
			endcase
		end
	end

	// Per-step increment of the linear ramp, spreading the remainder evenly
	logic [CW-1:0] lenSafe;
	logic [7:0]    stepQuot;
	logic [CW-1:0] stepRem;
	logic [CW:0]   errSum;
	logic          stepCarry;
	logic [7:0]    stepSize;
	logic          lastState;
	logic          stepNow;
	always_comb begin
		lenSafe   = (edgeLen == '0) ? CW'(1) : edgeLen;
		stepQuot  = 8'(edgeDelta / lenSafe);
		stepRem   = CW'(edgeDelta % lenSafe);
		errSum    = {1'b0, errAcc} + {1'b0, stepRem};
		stepCarry = errSum >= {1'b0, lenSafe};
		stepSize  = stepQuot + {7'h00, stepCarry};
		lastState = edgeStep == CW'(edgeLen - CW'(1));
		// A state ends on its last carrier cycle
		stepNow   = carrierTick && (!edgeStretch || holdCnt);
	end

	// Edge sequencer
	logic [7:0] startLevel;
	logic [7:0] goalLevel;
	logic       goDown;
	always_comb begin
		next_state       = state;
		next_amplitude   = amplitude;
		next_edgeStep    = edgeStep;
		next_edgeLen     = edgeLen;
		next_edgeStretch = edgeStretch;
		next_holdCnt     = holdCnt;
		next_edgeDelta   = edgeDelta;
		next_edgeTarget  = edgeTarget;
		next_errAcc      = errAcc;
		next_edgeFalling = edgeFalling;
		next_activeShape = activeShape;
		startLevel       = amplitude;
		goDown           = (state == ces_pkg::CES_FULL);
		goalLevel        = goDown ? residualCarrierLevelB
		                          : ces_pkg::LEVEL_FULL;
		case (state)
			ces_pkg::CES_FULL, ces_pkg::CES_LOW: begin
				// Settled level follows the residual setting while low
				if (state == ces_pkg::CES_LOW) begin
					next_amplitude = residualCarrierLevelB;
					startLevel     = residualCarrierLevelB;
				end
				if (modActive == goDown) begin
					next_edgeLen     = edgeShapeLengthA[
						ces_pkg::COUNT_LSB +: CW];
					next_edgeStretch = edgeShapeLengthA[
						ces_pkg::STRETCH_BIT];
					next_edgeTarget  = goalLevel;
					next_edgeDelta   = goDown ? startLevel - goalLevel
					                          : goalLevel - startLevel;
					next_edgeFalling = goDown;
					next_activeShape = goDown ? edgeShape[0] : edgeShape[1];
					next_edgeStep    = '0;
					next_errAcc      = '0;
					next_holdCnt     = 1'b0;
					if (next_edgeLen == '0) begin
						next_amplitude = goalLevel;
						next_state = goDown ? ces_pkg::CES_LOW
						                    : ces_pkg::CES_FULL;
					end else begin
						next_state = goDown ? ces_pkg::CES_FALL
						                    : ces_pkg::CES_RISE;
					end
				end
			end
			ces_pkg::CES_FALL, ces_pkg::CES_RISE: begin
				if (carrierTick) begin
					next_holdCnt = edgeStretch && !holdCnt;
				end
				if (stepNow) begin
					if (lastState) begin
						next_amplitude = edgeTarget;
						next_state = edgeFalling ? ces_pkg::CES_LOW
						                         : ces_pkg::CES_FULL;
					end else begin
						next_amplitude = edgeFalling ? amplitude - stepSize
						                             : amplitude + stepSize;
						next_edgeStep  = edgeStep + CW'(1);
					end
					next_errAcc = stepCarry ? CW'(errSum - {1'b0, lenSafe})
					                        : CW'(errSum);
				end
			end
			default: next_state = ces_pkg::CES_FULL;
		endcase
	end

	assign edgeBusy = (state == ces_pkg::CES_FALL) ||
	                  (state == ces_pkg::CES_RISE);

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			edgeShapeTypeA        <= ces_pkg::RST_TYPE;
			edgeShapeTimingA      <= ces_pkg::RST_TIMING;
			edgeShapeLengthA      <= ces_pkg::RST_LENGTH;
			residualCarrierLevelB <= ces_pkg::RST_RESIDUAL;
			awHeld      <= 1'b0;
			awAddrQ     <= '0;
			wHeld       <= 1'b0;
			wByteQ      <= '0;
			wLaneQ      <= 1'b0;
			bvalid      <= 1'b0;
			bresp       <= ces_pkg::RESP_OKAY;
			rvalid      <= 1'b0;
			rdata       <= '0;
			rresp       <= ces_pkg::RESP_OKAY;
			state       <= ces_pkg::CES_FULL;
			amplitude   <= ces_pkg::LEVEL_FULL;
			edgeStep    <= '0;
			edgeLen     <= '0;
			edgeStretch <= 1'b0;
			holdCnt     <= 1'b0;
			edgeDelta   <= '0;
			edgeTarget  <= ces_pkg::LEVEL_FULL;
			errAcc      <= '0;
			edgeFalling <= 1'b0;
			activeShape <= '0;
		end else begin
			edgeShapeTypeA        <= next_edgeShapeTypeA;
			edgeShapeTimingA      <= next_edgeShapeTimingA;
			edgeShapeLengthA      <= next_edgeShapeLengthA;
			residualCarrierLevelB <= next_residualCarrierLevelB;
			awHeld      <= next_awHeld;
			awAddrQ     <= next_awAddrQ;
			wHeld       <= next_wHeld;
			wByteQ      <= next_wByteQ;
			wLaneQ      <= next_wLaneQ;
			bvalid      <= next_bvalid;
			bresp       <= next_bresp;
			rvalid      <= next_rvalid;
			rdata       <= next_rdata;
			rresp       <= next_rresp;
			state       <= next_state;
			amplitude   <= next_amplitude;
			edgeStep    <= next_edgeStep;
			edgeLen     <= next_edgeLen;
			edgeStretch <= next_edgeStretch;
			holdCnt     <= next_holdCnt;
			edgeDelta   <= next_edgeDelta;
			edgeTarget  <= next_edgeTarget;
			errAcc      <= next_errAcc;
			edgeFalling <= next_edgeFalling;
			activeShape <= next_activeShape;
		end
	end
endmodule : ces_shaper
`default_nettype wire

// file: tb/ces_shaper_checker.sv
// Checker for the carrier edge shaper: bus answers and edge sequencing.
// Assumes it is bound to ces_shaper and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ces_shaper_checker (
	// Clock and reset
	input wire logic                clk,
	input wire logic                rstn,
	// Bus answers
	input wire logic [1:0]          bresp,
	input wire logic                bvalid,
	input wire logic                bready,
	input wire logic                arvalid,
	input wire logic                arready,
	input wire logic [31:0]         rdata,
	input wire logic                rvalid,
	input wire logic                rready,
	// Edge sequencing
	input wire logic                carrierTick,
	input wire logic [7:0]          amplitude,
	input wire logic [4:0]          edgeStep,
	input wire logic                edgeBusy,
	input wire logic                edgeFalling,
	input wire ces_pkg::ces_shape_t activeShape
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Answers stand until the master takes them; a read answers one cycle after its address
	AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped before it was taken");
	AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped before it was taken");
	AST_READ_LAT: assert property (arvalid && arready |=> rvalid)
		else $error("read answer not one cycle after the address");
	// Amplitude and state index move only on carrier ticks while an edge runs
	AST_AMP_TICK: assert property (edgeBusy && !carrierTick |=>
		$stable(amplitude) || !edgeBusy)
		else $error("amplitude moved without a carrier tick");
	AST_STEP_TICK: assert property (edgeBusy && !carrierTick |=>
		$stable(edgeStep) || !edgeBusy)
		else $error("state index moved without a carrier tick");
	// Idle after a rise means full carrier
	AST_FULL_IDLE: assert property (!edgeBusy && !edgeFalling |->
		amplitude == ces_pkg::LEVEL_FULL)
		else $error("carrier not full while idle");
	// Ramps are monotonic
	AST_FALL_DOWN: assert property (edgeBusy && edgeFalling |=>
		amplitude <= $past(amplitude))
		else $error("amplitude rose during a falling edge");
	AST_RISE_UP: assert property (edgeBusy && !edgeFalling |=>
		amplitude >= $past(amplitude))
		else $error("amplitude fell during a rising edge");
	// Shape kinds exclude each other; correction needs table adaptation
	AST_SHAPE_KIND: assert property (edgeBusy |->
		!(activeShape.fwShaping && activeShape.lutShaping))
		else $error("edge is both firmware and table shaped");
	AST_CORR_LUT: assert property (edgeBusy && activeShape.supplyCorrect |->
		activeShape.supplyAdapt && activeShape.lutShaping)
		else $error("correction without table adaptation");

	// Main scenarios reached
	cover property (edgeBusy && edgeFalling && carrierTick);
	cover property (bvalid && bresp == ces_pkg::RESP_DECERR);
	cover property (edgeBusy && activeShape.lutShaping);
endmodule : ces_shaper_checker

bind ces_shaper ces_shaper_checker ces_shaper_checker_inst (.clk, .rstn,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
	.carrierTick, .amplitude, .edgeStep, .edgeBusy, .edgeFalling,
	.activeShape);
`default_nettype wire

// file: tb/ces_shaper_tb.sv
// Self-checking bench for the carrier edge shaper.
// Assumes the checker is bound in and the carrier tick comes from here.
`timescale 1ns/1ps
`default_nettype none
module ces_shaper_tb;
	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	logic [11:0]         awaddr = 12'h0;
	logic                awvalid = 1'b0;
	logic                awready;
	logic [31:0]         wdata = 32'h0;
	logic [3:0]          wstrb = 4'h1;
	logic                wvalid = 1'b0;
	logic                wready;
	logic [1:0]          bresp;
	logic                bvalid;
	logic                bready = 1'b0;
	logic [11:0]         araddr = 12'h0;
	logic                arvalid = 1'b0;
	logic                arready;
	logic [31:0]         rdata;
	logic [1:0]          rresp;
	logic                rvalid;
	logic                rready = 1'b0;
	logic                carrierTick = 1'b0;
	logic                modActive = 1'b0;
	logic [7:0]          amplitude;
	logic [4:0]          edgeStep;
	logic                edgeBusy;
	logic                edgeFalling;
	ces_pkg::ces_shape_t activeShape;
	logic [1:0]          tickCnt = 2'h0;
	int                  err_count = 0;
	int                  checks_done = 0;
	localparam logic [11:0] ADR [4] = '{12'h0f4, 12'h0f8, 12'h0fc, 12'h100};
	localparam logic [7:0]  MSK [4] = '{8'hff, 8'h77, 8'h9f, 8'hff};
	localparam logic [7:0]  LEN [4] = '{8'h01, 8'h81, 8'h1f, 8'h9f};
	localparam int          TCK [4] = '{1, 2, 31, 62};

	ces_shaper ces_shaper_inst (.clk, .rstn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .carrierTick,
		.modActive, .amplitude, .edgeStep, .edgeBusy, .edgeFalling,
		.activeShape);

	// Clock at 100 MHz
	always #5 clk = ~clk;

	// Carrier tick on every fourth clock
	always @(posedge clk) begin
		tickCnt <= tickCnt + 2'h1;
		carrierTick <= tickCnt == 2'h3;
	end

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string n);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// One register write; bready stands until the answer is sampled
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// One register read; rready stands until the answer is sampled
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	// Request one edge, latch its shape and count the ticks it consumes
	task automatic run(input logic m, output ces_pkg::ces_shape_t sh,
		output int t);
		t = 0;
		@(posedge clk);
		modActive <= m;
		while (edgeBusy !== 1'b1) @(posedge clk);
		sh = activeShape;
		while (edgeBusy === 1'b1) begin
			t = t + int'(carrierTick);
			@(posedge clk);
		end
	endtask : run

	// Expected shape fields for a code and a selection
	function automatic logic [11:0] want(input logic [3:0] c,
		input logic [2:0] s);
		logic f;
		logic l;
		f = c >= 4'h1 && c <= 4'h3;
		l = c >= 4'h4 && c <= 4'h6;
		want = {f, l, f ? c[1:0] : 2'h0, f ? s : 3'h0, l ? s[1:0] : 2'h0,
			c == 4'h5 || c == 4'h6, c == 4'h5, 1'b0};
	endfunction : want

	// The same fields taken from a latched shape
	function automatic logic [11:0] seen(input ces_pkg::ces_shape_t a);
		seen = {a.fwShaping, a.lutShaping, a.fwShaping ? a.segments : 2'h0,
			a.fwShaping ? a.timeConst : 3'h0,
			a.lutShaping ? a.lutIndex : 2'h0,
			a.supplyAdapt, a.supplyCorrect, a.reservedCode};
	endfunction : seen

	// Verdict and end of run
	task automatic give_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// Hang guard, far beyond the expected run
	initial begin : watchdog
		#200000;
		err_count++;
		give_verdict();
	end

	// Test sequence
	initial begin : main
		ces_pkg::ces_shape_t sh;
		int t;
		logic [1:0] r;
		logic [31:0] d;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		chk(amplitude, 8'hff, "amplitude after reset");
		// Reset values, then masked write-back of every setting
		for (int i = 0; i < 4; i++) begin
			rd(ADR[i], d, r);
			chk(d, 32'h0, "reset value");
			wr(ADR[i], 8'hff, r);
			chk(r, ces_pkg::RESP_OKAY, "write answer");
			rd(ADR[i], d, r);
			chk(d, {24'h0, MSK[i]}, "masked value");
		end
		// Unmapped place is refused both ways
		wr(12'h200, 8'h55, r);
		chk(r, ces_pkg::RESP_DECERR, "unmapped write");
		rd(12'h200, d, r);
		chk(r, ces_pkg::RESP_DECERR, "unmapped read");
		chk(d, 32'h0, "unmapped data");
		// Codes 1 to 6 on both edges, falling and rising codes differ
		wr(12'h0f8, 8'h21, r);
		wr(12'h0fc, 8'h01, r);
		wr(12'h100, 8'h40, r);
		for (int c = 1; c < 7; c++) begin
			wr(12'h0f4, {4'(c), 4'(7 - c)}, r);
			run(1'b1, sh, t);
			chk(seen(sh), want(4'(c), 3'h2), "fall shape");
			chk(amplitude, 8'h40, "residual level");
			run(1'b0, sh, t);
			chk(seen(sh), want(4'(7 - c), 3'h1), "rise shape");
			chk(amplitude, 8'hff, "full level");
		end
		// State count and stretch, shortest and longest, zero residual
		wr(12'h100, 8'h00, r);
		for (int i = 0; i < 4; i++) begin
			wr(12'h0fc, LEN[i], r);
			run(1'b1, sh, t);
			chk(32'(t), 32'(TCK[i]), "fall ticks");
			chk(amplitude, 8'h00, "no carrier");
			chk(edgeFalling, 1'b1, "fall flag");
			run(1'b0, sh, t);
			chk(32'(t), 32'(TCK[i]), "rise ticks");
			chk(amplitude, 8'hff, "full level");
		end
		// Status place takes writes without effect and reports the last edge
		wr(12'h104, 8'h55, r);
		chk(r, ces_pkg::RESP_OKAY, "status write");
		rd(12'h104, d, r);
		chk(d, 32'h00001eff, "status after rise");
		give_verdict();
	end
endmodule : ces_shaper_tb
`default_nettype wire
